// >>> verilog/pptp_pkg.sv
// Package with the shared constants of the push-pull pulse-train PWM logic.
package pptp_pkg;
	// Number of flip-flops in each pin synchroniser.
	localparam int SYNC_STAGES = 2;
	// Reset value of the overcurrent flag: high until supplies are good.
	localparam logic FLAG_RESET = 1'h1;
	// Reset value of the steering bit: first pulse goes to output a.
	localparam logic STEER_RESET = 1'h0;
	// Supply-good debounce time and its cycle count at 50 MHz.
	localparam int CLK_HZ = 50000000;
	localparam int SUPPLY_SETTLE_NS = 200;
	localparam int SUPPLY_SETTLE_CYC =
		(SUPPLY_SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int SETTLE_W = 4;
	// States of the start-up sequencer, one-hot.
	typedef enum logic [2:0] {
		PPTP_ST_WAIT = 3'h1,
		PPTP_ST_SETTLE = 3'h2,
		PPTP_ST_RUN = 3'h4
	} pptp_state_t;
endpackage

// >>> verilog/pptp_sync.sv
// Two-stage synchroniser for one asynchronous pin.
`timescale 1ns/10ps
module pptp_sync (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Asynchronous level in, synchronised level out.
	input wire logic async_i,
	output logic sync_o
);
	logic meta_q;
	logic sync_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'h0;
			sync_q <= 1'h0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule

// >>> verilog/pptp_core.sv
// Digital control logic of a push-pull pulse-train PWM controller.
// Functional notes
// [RULE1] Each pulse-train rising edge starts a period.
// [RULE2] Ignore pulse train while reference-good low.
// [RULE3] Pulse train low disables both drive outputs.
// [RULE4] Current trip ends pulse, sets overcurrent flag.
// [RULE5] Each output switches at half pulse frequency.
// [RULE6] Flag held high until supplies are good.
// [RULE7] Supplies good: flag low, then process edges.
// [RULE8] Host waits for flag low before pulsing.
// [RULE9] Host soft-starts by ramping pulse duty.
// [RULE10] Host may clamp high time for volt-seconds.
// [RULE11] Host chooses its overcurrent response policy.
// [RULE12] Trip above threshold minus margin forces low.
// [RULE13] Flag latched until next pulse-train rising edge.
// [RULE14] Outputs alternate, never both active together.
`timescale 1ns/10ps
module pptp_core (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Asynchronous inputs from pins and analog circuitry.
	input wire logic pulse_train_i,
	input wire logic ref_good_i,
	input wire logic supplies_ok_i,
	input wire logic current_trip_i,
	// Drive outputs and host flag.
	output logic drive_output_a_o,
	output logic drive_output_b_o,
	output logic overcurrent_flag_o
);
	// Synchronised copies of the asynchronous inputs.
	logic pt_s;
	logic ref_s;
	logic sup_s;
	logic trip_s;
	logic pt_q;
	pptp_pkg::pptp_state_t state_q;
	pptp_pkg::pptp_state_t state_d;
	logic [pptp_pkg::SETTLE_W-1:0] settle_q;
	logic [pptp_pkg::SETTLE_W-1:0] settle_d;
	logic steer_q;
	logic steer_d;
	logic active_q;
	logic active_d;
	logic flag_q;
	logic flag_d;
	logic a_q;
	logic b_q;

	// The pulse train is the only timing reference, so it is synced too.
	pptp_sync u_sync_pt (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i(pulse_train_i),
		.sync_o(pt_s)
	);

	// Reference-good qualifier from the analog side.
	pptp_sync u_sync_ref (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i(ref_good_i),
		.sync_o(ref_s)
	);

	// Supply monitor; a glitch here drops the block back to waiting.
	pptp_sync u_sync_sup (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i(supplies_ok_i),
		.sync_o(sup_s)
	);

	// Current-limit comparator; the analog side applies the margin.
	pptp_sync u_sync_trip (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i(current_trip_i),
		.sync_o(trip_s)
	);

	// Decode of edges and qualifiers.
	wire run = (state_q == pptp_pkg::PPTP_ST_RUN);
	wire rise = run && pt_s && !pt_q; // RULE1 RULE2
	wire settled = (settle_q == pptp_pkg::SETTLE_W'(
		pptp_pkg::SUPPLY_SETTLE_CYC));
	wire good = ref_s && sup_s;
	// Entry into run clears the flag so the host knows it may start.
	wire run_next = (state_d == pptp_pkg::PPTP_ST_RUN);
	wire enter = run_next && !run; // RULE7
	// A trip only counts while a pulse is open or opening.
	wire trip_hit = run && trip_s && (active_q || rise); // RULE4

	// Start-up sequencer; supply loss drops back to waiting.
	always_comb begin
		state_d = state_q;
		settle_d = settle_q;
		case (state_q)
			pptp_pkg::PPTP_ST_WAIT: begin
				settle_d = '0;
				if (good) begin
					state_d = pptp_pkg::PPTP_ST_SETTLE;
				end
			end
			pptp_pkg::PPTP_ST_SETTLE: begin
				settle_d = settle_q + pptp_pkg::SETTLE_W'(1);
				if (!good) begin
					state_d = pptp_pkg::PPTP_ST_WAIT;
				end else if (settled) begin
					state_d = pptp_pkg::PPTP_ST_RUN; // RULE7
				end
			end
			pptp_pkg::PPTP_ST_RUN: begin
				if (!good) begin
					state_d = pptp_pkg::PPTP_ST_WAIT; // RULE2 RULE6
				end
			end
			default: begin
				state_d = pptp_pkg::PPTP_ST_WAIT;
			end
		endcase
	end

	// Pulse steering: a rising edge flips sides and opens a pulse.
	assign steer_d = rise ? !steer_q : steer_q; // RULE5 RULE14
	assign active_d = run && pt_s && !trip_s &&
		(rise || active_q); // RULE3 RULE4 RULE12
	// Flag: high out of run, low on entry, set by trip, cleared by edge.
	// A trip in the edge's own cycle wins, so no event is lost.
	// Leaving run in any cycle forces the flag high again.
	assign flag_d = !run_next ? 1'h1 : // RULE6
		trip_hit ? 1'h1 : // RULE4 RULE12
		(rise || enter) ? 1'h0 : // RULE7 RULE13
		flag_q;

	// State registers.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q <= pptp_pkg::PPTP_ST_WAIT;
			settle_q <= '0;
			pt_q <= 1'h0;
			steer_q <= pptp_pkg::STEER_RESET;
			active_q <= 1'h0;
			flag_q <= pptp_pkg::FLAG_RESET;
		end else begin
			state_q <= state_d;
			settle_q <= settle_d;
			pt_q <= pt_s;
			steer_q <= steer_d;
			active_q <= active_d;
			flag_q <= flag_d;
		end
	end

	// Output flops; only one side can ever be selected.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			a_q <= 1'h0;
			b_q <= 1'h0;
		end else begin
			a_q <= active_d && steer_d; // RULE14
			b_q <= active_d && !steer_d; // RULE14
		end
	end

	// Every output comes straight from a flop, so pins never glitch.
	assign drive_output_a_o = a_q;
	assign drive_output_b_o = b_q;
	assign overcurrent_flag_o = flag_q;

	// Checks on the drive and flag behaviour.
	never_both_a: assert property ( // RULE14
		@(posedge clk_i) disable iff (!rst_n_i)
		!(a_q && b_q)) else $error("both outputs on");
	low_disables_a: assert property ( // RULE3
		@(posedge clk_i) disable iff (!rst_n_i)
		!pt_s |=> !a_q && !b_q) else $error("drive while low");
	trip_off_a: assert property ( // RULE4
		@(posedge clk_i) disable iff (!rst_n_i)
		trip_s |=> !a_q && !b_q) else $error("drive after trip");
	trip_flag_a: assert property ( // RULE12
		@(posedge clk_i) disable iff (!rst_n_i)
		trip_s && active_q |=> flag_q) else $error("flag not set");
	notrun_flag_a: assert property ( // RULE6
		@(posedge clk_i) disable iff (!rst_n_i)
		!run && !enter |=> flag_q) else $error("flag low early");
	notrun_off_a: assert property ( // RULE2
		@(posedge clk_i) disable iff (!rst_n_i)
		!run |=> !a_q && !b_q) else $error("drive before run");
	alternate_a: assert property ( // RULE5
		@(posedge clk_i) disable iff (!rst_n_i)
		rise |=> steer_q != $past(steer_q)) else $error("no flip");
	flag_hold_a: assert property ( // RULE13
		@(posedge clk_i) disable iff (!rst_n_i)
		run && flag_q && !rise && $past(run) |=> flag_q)
		else $error("flag cleared without edge");
	edge_clear_a: assert property ( // RULE1
		@(posedge clk_i) disable iff (!rst_n_i)
		rise && !trip_s && $past(run) && good |=> !flag_q)
		else $error("flag not cleared");
	settle_run_a: assert property ( // RULE7
		@(posedge clk_i) disable iff (!rst_n_i)
		state_q == pptp_pkg::PPTP_ST_SETTLE && settled && good
		|=> run) else $error("no run");
	// Start-up, edge and steering checks.
	ref_low_a: assert property ( // RULE2
		@(posedge clk_i) disable iff (!rst_n_i)
		!ref_s |=> !run) else $error("run without reference");
	enter_clear_a: assert property ( // RULE7
		@(posedge clk_i) disable iff (!rst_n_i)
		enter |=> run && !flag_q) else $error("flag high in run");
	flag_fall_a: assert property ( // RULE13
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(flag_q) |-> $past(rise) || $past(enter))
		else $error("flag fell without cause");
	pulse_edge_a: assert property ( // RULE1
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(a_q) || $rose(b_q) |-> $past(rise))
		else $error("pulse without edge");
	steer_hold_a: assert property ( // RULE5
		@(posedge clk_i) disable iff (!rst_n_i)
		!rise |=> $stable(steer_q)) else $error("steer moved");
	// Covers for the main scenarios.
	cov_a_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) a_q);
	cov_b_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) b_q);
	cov_trip_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		trip_s && active_q);
	cov_enter_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		enter);
	cov_clear_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		rise && flag_q);
endmodule

// >>> verification/pptp_host.sv
// Host model that sends a fixed-period pulse train with a chosen high time.
`timescale 1ns/10ps
module pptp_host #(
	parameter int PERIOD = 16
) (
	// Clock and control from the bench.
	input wire logic clk_i,
	input wire logic en_i,
	input wire logic [7:0] high_i,
	// Pulse train towards the device.
	output logic pulse_o
);
	int cnt = 0;
	// Frequency stays fixed while the high time may vary per period.
	always @(posedge clk_i) begin
		cnt <= (en_i && cnt < PERIOD - 1) ? cnt + 1 : 0;
		pulse_o <= #1 en_i && (cnt < int'(high_i));
	end
endmodule

// >>> verification/pptp_tb.sv
// Self-checking bench for the push-pull pulse-train logic.
`timescale 1ns/10ps
module push_pull_pulse_train_pwm_logic_tb_top;
	logic clk_i = 0, rst_n_i = 0, rg = 0, sok = 0, trip = 0, en = 0;
	logic [7:0] high = 8'h06;
	logic pulse, a, b, flag, pa = 0, pb = 0;
	int n_fail = 0, checks_done = 0, na = 0, nb = 0, nhi = 0;
	always #10 clk_i = ~clk_i;
	pptp_host pptp_host_i(.clk_i(clk_i), .en_i(en), .high_i(high),
		.pulse_o(pulse));
	pptp_core pptp_core_i(.clk_i(clk_i), .rst_n_i(rst_n_i),
		.pulse_train_i(pulse), .ref_good_i(rg), .supplies_ok_i(sok),
		.current_trip_i(trip), .drive_output_a_o(a),
		.drive_output_b_o(b), .overcurrent_flag_o(flag));
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Counts pulses on each output and the cycles either one is high.
	always @(posedge clk_i) begin
		if (a && !pa) na++;
		if (b && !pb) nb++;
		if (a || b) nhi++;
		if (a && b) check("both", 1, 0);
		pa <= a;
		pb <= b;
	end
	task automatic t_start();
		step(8);
		rst_n_i = 1;
		check("flag", flag, 1);
		en = 1;
		step(40);
		check("pulses", na + nb, 0);
		check("flag", flag, 1);
		en = 0;
	endtask
	task automatic t_run();
		int i;
		rg = 1;
		step(20);
		check("flag", flag, 1);
		sok = 1;
		// The host only starts once it has seen the flag go low.
		for (i = 0; i < 40 && flag; i++) step(1);
		check("settle", i, 4 + pptp_pkg::SUPPLY_SETTLE_CYC);
		{na, nb, nhi} = 0;
		en = 1;
		step(64);
		en = 0;
		step(20);
		check("na", na, 2);
		check("nb", nb, 2);
		check("hi", nhi, 24);
		check("flag", flag, 0);
	endtask
	task automatic t_trip();
		int i;
		high = 8'h0A;
		en = 1;
		for (i = 0; i < 40 && !(a || b); i++) step(1);
		trip = 1;
		step(3);
		check("drv", a || b, 0);
		check("flag", flag, 1);
		trip = 0;
		step(4);
		check("hold", flag, 1);
		// This host tolerates the event and simply keeps pulsing.
		for (i = 0; i < 30 && flag; i++) step(1);
		check("clear", {flag, a || b}, 2'h1);
		en = 0;
	endtask
	// Losing the reference in run must stop drives and raise the flag.
	task automatic t_drop();
		rg = 0;
		step(4);
		check("drop flag", flag, 1);
		{na, nb} = 0;
		en = 1;
		step(40);
		check("drop pulses", na + nb, 0);
		check("drop drv", a || b, 0);
		en = 0;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		t_start();
		t_run();
		t_trip();
		t_drop();
		give_verdict();
	end
	// A hang past more than four times the expected run counts as a failure.
	initial begin
		#20000;
		n_fail++;
		give_verdict();
	end
endmodule
